// ---- pcgp_pkg.sv ----
// Purpose: shared constants for the pad configuration and gpio port
// Assumes: twelve pins, three-bit function select, two-bit pull mode
// Notes:   pin positions of special pads are fixed here
package pcgp_pkg;
	localparam int NPINS = 12;
	localparam int FUNCTION_SELECT_FIELD_W = 3;
	localparam int LVL_W = 4;
	// function select codes
	localparam logic [2:0] FUNCTION_SELECT_FIELD_GPIO = 3'h0;
	// pull mode encodings
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_PULLDOWN = 2'h1;
	localparam logic [1:0] MODE_PULLUP = 2'h2;
	localparam logic [1:0] MODE_REPEATER = 2'h3;
	// special pad positions
	localparam int HS_PAD_A = 3;
	localparam int I2C_PAD_A = 4;
	localparam int I2C_PAD_B = 5;
	localparam int HS_PAD_B = 7;
	localparam int DBG_HS_PAD_A = 10;
	localparam int DBG_HS_PAD_B = 11;
	// reset values
	localparam logic [11:0] DIR_RST = 12'h000;
	localparam logic [11:0] OUT_RST = 12'h000;
	localparam logic [11:0] SPECIAL_MASK = 12'hC30;
	// access operation codes
	typedef enum logic [2:0] {PCGP_OP_WRITE, PCGP_OP_MASKED, PCGP_OP_SET, PCGP_OP_CLR,
		PCGP_OP_TGL} pcgp_op_t;
endpackage

// ---- pcgp_sync.sv ----
// Purpose: two-flop synchroniser bank for pin levels
// Assumes: inputs asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
module pcgp_sync #(
	parameter int W = 12
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// two stages, reset to low
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= '0;
			q <= '0;
		end
		else
		begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule // pcgp_sync

// ---- pcgp_port.sv ----
// Purpose: pad configuration and gpio port for one twelve-pin port
// Assumes: one clock, config bits arrive as plain ports, peripheral drives given per pin
// Notes:   every output is registered, so pad controls lag config by one cycle
// Summary of operation
// - function code zero selects gpio, any other code selects the peripheral.
// - in gpio mode the direction bit enables or disables the driver.
// - peripheral mode uses peripheral direction, direction register ignored.
// - per-pin mode selects pull-up, pull-down, none or repeater.
// - pull mode resets to no resistor.
// - repeater pulls toward the level the pin currently reads.
// - undriven repeater input keeps its last level outside deep power-down.
// - repeater keeping may be dropped during deep power-down.
// - each pad has input mode, hysteresis and filter settings.
// - i2c pads choose filtered i2c mode or plain open-drain without filter.
// - high-source pads choose digital output or current-sink mode.
// - current sink switches between low and high level by output value.
// - masked, set and clear writes change only chosen output bits.
// - a whole-port write updates all output bits at once.
// - each port access completes in one clock cycle.
// - direction bits can be set, cleared and toggled individually.
// - after reset pins are gpio inputs without pulls, special pads included.
// - each port bit maps to a fixed pin, never relocated.
`timescale 1ns/1ps
module pcgp_port
	import pcgp_pkg::*;
#(
	parameter int N = pcgp_pkg::NPINS
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// power state
	input  wire logic                   deep_pdn,
	// pad configuration, per pin
	input  wire logic [N*FUNCTION_SELECT_FIELD_W-1:0]    function_select_field,
	input  wire logic [2*N-1:0]         pull_mode,
	input  wire logic [N-1:0]           input_invert,
	input  wire logic [N-1:0]           hyst_en,
	input  wire logic [N-1:0]           filter_en,
	input  wire logic [1:0]             i2c_plain_od,
	input  wire logic [3:0]             sink_mode,
	input  wire logic [4*LVL_W-1:0]     low_sink_level_field,
	input  wire logic [4*LVL_W-1:0]     high_sink_level_field,
	// peripheral side, per pin
	input  wire logic [N-1:0]           periph_out,
	input  wire logic [N-1:0]           periph_oe,
	output logic      [N-1:0]           periph_in,
	// port access from the processor i/o bus
	input  wire logic                   data_wr,
	input  wire logic                   dir_wr,
	input  wire pcgp_pkg::pcgp_op_t     op,
	input  wire logic [N-1:0]           wdata,
	input  wire logic [N-1:0]           wmask,
	input  wire logic                   rd,
	output logic      [N-1:0]           rdata,
	output logic      [N-1:0]           port_direction_register,
	output logic      [N-1:0]           port_out,
	// pads
	input  wire logic [N-1:0]           port0_pin_n_level,
	output logic      [N-1:0]           port0_pin_n_drive,
	output logic      [N-1:0]           port0_pin_n_oe,
	output logic      [N-1:0]           pull_up_en,
	output logic      [N-1:0]           pull_down_en,
	output logic      [N-1:0]           hyst_out,
	output logic      [N-1:0]           filter_out,
	output logic      [3:0]             sink_en,
	output logic      [4*LVL_W-1:0]     sink_level
);
	logic [N-1:0] pin_sync;
	logic [N-1:0] dir_ff;
	logic [N-1:0] out_ff;
	logic [N-1:0] nxt_dir;
	logic [N-1:0] nxt_out;
	logic [N-1:0] rdata_ff;
	logic [N-1:0] o_ff;
	logic [N-1:0] oe_ff;
	logic [N-1:0] pu_ff;
	logic [N-1:0] pd_ff;
	logic [N-1:0] hy_ff;
	logic [N-1:0] fl_ff;
	logic [N-1:0] pin_in_ff;
	logic [N-1:0] nxt_o;
	logic [N-1:0] nxt_oe;
	logic [N-1:0] nxt_pu;
	logic [N-1:0] nxt_pd;
	logic [N-1:0] nxt_fl;
	logic [N-1:0] sel_gpio;
	logic [3:0]   sink_ff;
	logic [4*LVL_W-1:0] lvl_ff;
	logic [3:0]   nxt_sink;
	logic [4*LVL_W-1:0] nxt_lvl;

	// pad inputs come from outside the clock domain
	pcgp_sync #(
		.W(N)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (port0_pin_n_level),
		.q      (pin_sync)
	);

	// access decode; each op is one cycle, no wait states
	function automatic logic [N-1:0] apply_op(input logic [N-1:0] cur, input pcgp_op_t o,
		input logic [N-1:0] d, input logic [N-1:0] m);
		logic [N-1:0] r;
		r = cur;
		case (o)
			PCGP_OP_WRITE:  r = d;
			PCGP_OP_MASKED: r = (cur & ~m) | (d & m);
			PCGP_OP_SET:    r = cur | d;
			PCGP_OP_CLR:    r = cur & ~d;
			PCGP_OP_TGL:    r = cur ^ d;
			default:        r = cur;
		endcase
		return r;
	endfunction

	assign nxt_out = data_wr ? apply_op(out_ff, op, wdata, wmask) : out_ff;
	assign nxt_dir = dir_wr ? apply_op(dir_ff, op, wdata, wmask) : dir_ff;

	// per pin routing; bit i always lands on pin i
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_pin
			logic [FUNCTION_SELECT_FIELD_W-1:0] fsel;
			logic [1:0]        md;
			logic              is_i2c;
			logic              od;
			logic              drv;
			assign fsel = function_select_field[gi*FUNCTION_SELECT_FIELD_W +: FUNCTION_SELECT_FIELD_W];
			assign md = pull_mode[2*gi +: 2];
			assign is_i2c = (gi == I2C_PAD_A) || (gi == I2C_PAD_B);
			assign sel_gpio[gi] = (fsel == FUNCTION_SELECT_FIELD_GPIO);
			// i2c pads are open-drain in either i2c mode
			assign od = is_i2c && !sel_gpio[gi];
			assign drv = sel_gpio[gi] ? out_ff[gi] : periph_out[gi];
			assign nxt_o[gi] = od ? 1'b0 : drv;
			assign nxt_oe[gi] = od ? (periph_oe[gi] && !periph_out[gi]) :
				(sel_gpio[gi] ? dir_ff[gi] : periph_oe[gi]);
			assign nxt_pu[gi] = (md == MODE_PULLUP) ||
				(md == MODE_REPEATER && pin_sync[gi] && !deep_pdn);
			assign nxt_pd[gi] = (md == MODE_PULLDOWN) ||
				(md == MODE_REPEATER && !pin_sync[gi] && !deep_pdn);
			// plain open-drain mode drops filter
			// index stays in range on every pin, not only the two i2c pads
			assign nxt_fl[gi] = (is_i2c && !sel_gpio[gi]) ? !i2c_plain_od[gi == I2C_PAD_B] :
				filter_en[gi];
		end
	endgenerate

	// high-source pads: digital mode or current sink
	localparam int HS_IDX [4] = '{HS_PAD_A, HS_PAD_B, DBG_HS_PAD_A, DBG_HS_PAD_B};
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_hs
			logic val;
			assign val = nxt_o[HS_IDX[gi]];
			assign nxt_sink[gi] = sink_mode[gi];
			assign nxt_lvl[gi*LVL_W +: LVL_W] = val ?
				high_sink_level_field[gi*LVL_W +: LVL_W] :
				low_sink_level_field[gi*LVL_W +: LVL_W];
		end
	endgenerate

	// direction state; pins come up as inputs
	// gpio inputs after reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			dir_ff <= DIR_RST;
		else
			dir_ff <= nxt_dir;
	end

	// output data state, cleared so a later direction write drives low
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			out_ff <= OUT_RST;
		else
			out_ff <= nxt_out;
	end

	// pad drive and enable, registered so pads never see decode glitches
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			o_ff <= '0;
			oe_ff <= '0;
		end
		else
		begin
			o_ff <= nxt_o;
			oe_ff <= nxt_oe;
		end
	end

	// pull controls
	// pulls off at reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pu_ff <= '0;
			pd_ff <= '0;
		end
		else
		begin
			pu_ff <= nxt_pu;
			pd_ff <= nxt_pd;
		end
	end

	// input conditioning settings
	// hysteresis and filter
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hy_ff <= '0;
			fl_ff <= '0;
		end
		else
		begin
			hy_ff <= hyst_en;
			fl_ff <= nxt_fl;
		end
	end

	// current sink controls of the high-source pads
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sink_ff <= '0;
			lvl_ff <= '0;
		end
		else
		begin
			sink_ff <= nxt_sink;
			lvl_ff <= nxt_lvl;
		end
	end

	// peripheral input path; gpio pins read as zero here
	// input mode inversion
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pin_in_ff <= '0;
		else
			pin_in_ff <= (pin_sync ^ input_invert) & ~sel_gpio;
	end

	// read capture; holds until the next read strobe
	// raw synced level read
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_ff <= '0;
		else if (rd)
			rdata_ff <= pin_sync;
	end

	// outputs straight from flops
	assign rdata = rdata_ff;
	assign port_direction_register = dir_ff;
	assign port_out = out_ff;
	assign port0_pin_n_drive = o_ff;
	assign port0_pin_n_oe = oe_ff;
	assign pull_up_en = pu_ff;
	assign pull_down_en = pd_ff;
	assign hyst_out = hy_ff;
	assign filter_out = fl_ff;
	assign sink_en = sink_ff;
	assign sink_level = lvl_ff;
	assign periph_in = pin_in_ff;
endmodule // pcgp_port

// ---- pcgp_port_checker.sv ----
// Purpose: port-level checks of the pad and gpio port
// Assumes: twelve pins, one clock
// Notes:   pad outputs lag their causes by one cycle
`timescale 1ns/1ps
module pcgp_port_checker
	import pcgp_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              arst_n,
	// watched ports
	input wire logic              deep_pdn,
	input wire logic [35:0]       function_select_field,
	input wire logic [23:0]       pull_mode,
	input wire logic [11:0]       periph_oe,
	input wire logic              data_wr,
	input wire logic              dir_wr,
	input wire pcgp_pkg::pcgp_op_t op,
	input wire logic [11:0]       wdata,
	input wire logic [11:0]       wmask,
	input wire logic              rd,
	input wire logic [11:0]       rdata,
	input wire logic [11:0]       port_direction_register,
	input wire logic [11:0]       port_out,
	input wire logic [11:0]       port0_pin_n_level,
	input wire logic [11:0]       port0_pin_n_oe,
	input wire logic [11:0]       pull_up_en,
	input wire logic [11:0]       pull_down_en
);
	logic [11:0] gp;
	// per-pin gpio select
	for (genvar i = 0; i < 12; i++)
	begin : g_sel
		assign gp[i] = function_select_field[3*i+:3] == FUNCTION_SELECT_FIELD_GPIO;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// i2c pads left out of the peripheral check: they drive open drain
	gpio_dir_a: assert property (
		1'b1 |=> ((port0_pin_n_oe ^ $past(port_direction_register)) & $past(gp)) == 0)
		else $error("gpio enable off direction");
	periph_dir_a: assert property (
		1'b1 |=> ((port0_pin_n_oe ^ $past(periph_oe)) & ~$past(gp) & 12'hFCF) == 0)
		else $error("peripheral enable wrong");
	pull_sel_a: assert property (
		pull_mode[1:0] != MODE_REPEATER |=> pull_up_en[0] == ($past(pull_mode[1:0]) == MODE_PULLUP)
		&& pull_down_en[0] == ($past(pull_mode[1:0]) == MODE_PULLDOWN)) else $error("pull wrong");
	pull_excl_a: assert property ((pull_up_en & pull_down_en) == 0)
		else $error("both pulls on");
	pdn_drop_a: assert property (
		deep_pdn && pull_mode[7:6] == MODE_REPEATER |=> !pull_up_en[3] && !pull_down_en[3])
		else $error("keeper held in power-down");
	read_sync_a: assert property (
		rd && $stable(port0_pin_n_level) &&
		$past(port0_pin_n_level) == $past(port0_pin_n_level, 2)
		|=> rdata == $past(port0_pin_n_level)) else $error("read level wrong");
	dir_tgl_a: assert property (
		dir_wr && op == PCGP_OP_TGL |=> port_direction_register ==
		($past(port_direction_register) ^ $past(wdata))) else $error("toggle wrong");
	mask_wr_a: assert property (
		data_wr && op == PCGP_OP_MASKED |=> port_out ==
		(($past(port_out) & ~$past(wmask)) | ($past(wdata) & $past(wmask))))
		else $error("masked write wrong");
endmodule // pcgp_port_checker

// ---- pcgp_pads.sv ----
// Purpose: pins and outside circuitry seen by the port
// Assumes: pad driver beats outside drive, which beats the pulls
// Notes:   a floating pin flips every cycle, so it never looks kept
`timescale 1ns/1ps
module pcgp_pads (
	// clock
	input  wire logic        clk,
	// pad controls and outside drive
	input  wire logic [11:0] port0_pin_n_drive,
	input  wire logic [11:0] port0_pin_n_oe,
	input  wire logic [11:0] pull_up_en,
	input  wire logic [11:0] pull_down_en,
	input  wire logic [11:0] ext_en,
	input  wire logic [11:0] ext_val,
	// resolved level
	output logic      [11:0] port0_pin_n_level
);
	logic [11:0] last_ff = 12'h000;
	// last level, source of the floating pattern
	always_ff @(posedge clk) last_ff <= port0_pin_n_level;
	assign port0_pin_n_level = (port0_pin_n_oe & port0_pin_n_drive) |
		(~port0_pin_n_oe & ((ext_en & ext_val) |
		(~ext_en & (pull_up_en | (~pull_down_en & ~last_ff)))));
endmodule // pcgp_pads

// ---- pcgp_port_tb.sv ----
// Purpose: directed test of the pad and gpio port
// Assumes: inputs change on the falling edge
// Notes:   expected values are worked out by hand
`timescale 1ns/1ps
`define CHK(n, e, s) \
	begin tests_run++; if ((s) !== (e)) begin num_errors++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module pcgp_port_tb;
	import pcgp_pkg::*;
	// stimulus and observed signals
	logic clk = 0, arst_n = 0, deep_pdn = 0, data_wr = 0, dir_wr = 0, rd = 0;
	logic [35:0] function_select_field = '0;
	logic [23:0] pull_mode = '0;
	logic [15:0] low_sink_level_field = 16'h4321, high_sink_level_field = 16'h8765, sink_level;
	logic [11:0] input_invert = '0, hyst_en = '0, filter_en = '0, periph_out = '0, periph_oe = '0;
	logic [11:0] wdata = '0, wmask = '0, ext_en = '0, ext_val = '0, periph_in, rdata;
	logic [11:0] port_direction_register, port_out, port0_pin_n_level, port0_pin_n_drive;
	logic [11:0] port0_pin_n_oe, pull_up_en, pull_down_en, hyst_out, filter_out;
	logic [3:0]  sink_mode = '0, sink_en;
	logic [1:0]  i2c_plain_od = '0;
	pcgp_op_t    op = PCGP_OP_WRITE;
	int          num_errors = 0, tests_run = 0;
	pcgp_port dut (.*);
	pcgp_pads pads (.*);
	// 20 MHz clock
	initial forever #25 clk = ~clk;
	// one access per cycle; strobes stay up for back-to-back use
	task automatic acc(input logic dw, rw, input pcgp_op_t o, input logic [11:0] d, m);
		data_wr = dw;
		dir_wr = rw;
		op = o;
		wdata = d;
		wmask = m;
		@(negedge clk);
	endtask
	// drop strobes, let n cycles pass
	task automatic idle(input int n);
		data_wr = 0;
		dir_wr = 0;
		rd = 0;
		repeat (n) @(negedge clk);
	endtask
	// pins settle through the synchroniser before the read
	task automatic rdchk(input logic [11:0] e, m);
		idle(4);
		rd = 1;
		@(negedge clk);
		idle(1);
		`CHK("rdata", e, rdata & m)
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial
	begin
		repeat (16) @(negedge clk);
		arst_n = 1;
		idle(2);
		`CHK("dir", 12'h000, port_direction_register)
		`CHK("pulls", 12'h000, pull_up_en | pull_down_en)
		acc(1, 1, PCGP_OP_WRITE, 12'h0F0, 12'h000);
		acc(1, 0, PCGP_OP_MASKED, 12'hA5A, 12'h00F);
		acc(1, 1, PCGP_OP_SET, 12'h101, 12'h000);
		acc(1, 1, PCGP_OP_CLR, 12'h012, 12'h000);
		acc(0, 1, PCGP_OP_TGL, 12'h0FF, 12'h000);
		acc(1, 0, PCGP_OP_TGL, 12'h800, 12'h000);
		idle(3);
		`CHK("out", 12'h9E9, port_out)
		`CHK("dir", 12'h11E, port_direction_register)
		`CHK("oe", 12'h11E, port0_pin_n_oe)
		`CHK("drive", 12'h108, port0_pin_n_drive & 12'h11E)
		ext_en = 12'hEE1;
		ext_val = 12'h3C3;
		rdchk(12'h3C9, 12'hFFF);
		periph_oe = 12'h00A;
		periph_out = 12'h00F;
		// every peripheral code, direction register ignored
		for (int c = 1; c < 8; c++)
		begin
			function_select_field = {24'h00_0000, {4{c[2:0]}}};
			idle(2);
			`CHK("periph oe", 4'hA, port0_pin_n_oe[3:0])
		end
		function_select_field = '0;
		acc(0, 1, PCGP_OP_WRITE, 12'h000, 12'h000);
		ext_en = 12'h008;
		ext_val = 12'h008;
		pull_mode = 24'h00_00C6;
		idle(6);
		ext_en = 12'h000;
		idle(8);
		`CHK("pull up", 4'h9, pull_up_en[3:0])
		`CHK("pull down", 4'h2, pull_down_en[3:0])
		rdchk(12'h009, 12'h00B);
		deep_pdn = 1;
		idle(3);
		`CHK("pdn pulls", 2'b01, {pull_up_en[3], pull_up_en[0]})
		hyst_en = 12'h5A5;
		function_select_field = 36'h0_0000_9000;
		i2c_plain_od = 2'b01;
		sink_mode = 4'h1;
		// i2c pads: pin 4 released and held high outside, pin 5 pulled low by the pad
		periph_oe = 12'h03A;
		periph_out = 12'h01F;
		ext_en = 12'h010;
		ext_val = 12'h010;
		input_invert = 12'h020;
		idle(4);
		`CHK("hyst", 12'h5A5, hyst_out)
		`CHK("i2c filter", 2'b10, filter_out[5:4])
		`CHK("sink on", 4'h1, sink_en)
		`CHK("sink level", 4'h5, sink_level[3:0])
		`CHK("i2c drive", 4'h8, {port0_pin_n_oe[5:4], port0_pin_n_drive[5:4]})
		`CHK("periph in", 12'h030, periph_in)
		acc(1, 0, PCGP_OP_CLR, 12'h008, 12'h000);
		idle(3);
		`CHK("sink low", 4'h1, sink_level[3:0])
		give_verdict;
	end
endmodule // pcgp_port_tb
bind pcgp_port pcgp_port_checker chk (.*);
